// file: rtl/tmlp_regs.svh
// Overview of operation
// - mode control register sits at serial address 0x0a.
// - bits 7:5 set interrupt spacing factor 1..8 times master tick.
// - bit 4 written 0 resets the controller; 1 leaves it running.
// - bit 2 low enables duty cycling; high disables it.
// - bit 1 enables the interrupt output function.
// - bit 0 high enables electrode scanning, low stops it.
// - wake pin falling edge forces the duty-cycle-off bit to 1.
// - low-power period adaptation works only in cycled run mode.
// - normal period is ((tick+5)/8+1) x sample factor x 4 x 8ms.
// - slow period multiplies the normal period by the sleep cycle factor.
// - idle timeout is ((tick+5)/8+1) x sample x idle factor x 6 x 8ms.
// - start normal, go slow after idle timeout, back on touch.
// - low-power timing register sits at serial address 0x08.
// - bits 7:5 idle timeout factor; zero disables low power.
// - bits 4:0 sleep cycle factor; zero disables low power.
// - read-only live status at 0x02 shows at most one touch.
// - live status bit 4 is set while a touch is detected.
// - live status bits 3:0 give touched electrode index.
// - touch FIFO holds 30 events; further events are lost.
// - each FIFO read removes the returned entry.
// - FIFO empties on last read or on any write to it.
// - mode decodes from scan enable and duty-cycle-off bits.
// - in continuous run only the mode control register accepts writes; cycled run accepts none. Here a FIFO write still clears it in continuous run.
// - off stop mode neither scans nor answers serial access.
// - outside continuous run the primary tick is fixed 8ms.
`ifndef TMLP_REGS_SVH
`define TMLP_REGS_SVH
`define TMLP_ADDR_FIFO 8'h00
`define TMLP_ADDR_LIVE 8'h02
`define TMLP_ADDR_LOWPWR 8'h08
`define TMLP_ADDR_MODE 8'h0a
`define TMLP_MODE_RESET 8'h14
`define TMLP_LOWPWR_RESET 8'h00
`define TMLP_MODE_SPACING 7:5
`define TMLP_MODE_SOFTRST 4
`define TMLP_MODE_DCOFF 2
`define TMLP_MODE_INTERRUPT_OUT_ENABLE 1
`define TMLP_MODE_SCAN 0
`define TMLP_LP_IDLE 7:5
`define TMLP_LP_SLEEP 4:0
`define TMLP_FIXED_TICK_MS 8
`define TMLP_TICK_OFFSET_MS 5
`define TMLP_TICK_DIV 8
`define TMLP_DEBOUNCE 4
`define TMLP_IDLE_MULT 6
`define TMLP_SPACING_MULT 4
`define TMLP_FIFO_LIMIT 30
`endif

// file: rtl/tmlp_pkg.sv
package tmlp_pkg;
    typedef struct packed {
        logic touched;
        logic [3:0] position;
    } tmlp_touch_t;

    typedef enum logic [1:0] {
        MODE_CONT_RUN,
        MODE_CYCLED_RUN,
        MODE_IDLE_STOP,
        MODE_OFF_STOP
    } tmlp_mode_t;

    typedef enum logic {
        LP_NORMAL,
        LP_SLOW
    } tmlp_lp_state_t;
endpackage : tmlp_pkg

// file: rtl/tmlp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmlp_regs.svh"

module tmlp_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32,
    parameter int LIMIT = 30
) (
    input wire logic i_clk, // core clock
    input wire logic i_rst_n, // synchronised reset
    input wire logic i_clear, // drop all entries
    input wire logic i_s_valid, // source offers a word
    output logic o_s_ready, // room below the limit
    input wire logic [WIDTH-1:0] i_s_data, // source word
    output logic o_m_valid, // head word present
    input wire logic i_m_ready, // drain takes head
    output logic [WIDTH-1:0] o_m_data, // head word
    output logic [$clog2(DEPTH+1)-1:0] o_count // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    generate
        if (LIMIT > DEPTH || LIMIT < 1 || DEPTH < 2) begin : g_bad
            $error("tmlp_fifo: LIMIT must lie in 1..DEPTH");
        end
    endgenerate
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign o_s_ready = (count < CW'(LIMIT));
    assign o_m_valid = (count != '0);
    assign o_m_data = mem[rd_idx];
    assign o_count = count;
    assign push = i_s_valid && o_s_ready && !i_clear;
    assign pop = o_m_valid && i_m_ready && !i_clear;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_idx] <= i_s_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else if (i_clear) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule : tmlp_fifo

module tmlp_top #(
    parameter int MS_CYCLES = 250000,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic i_core_clk, // 250 MHz core clock
    input wire logic i_arst_n, // async reset, active low
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    input wire logic [7:0] i_reg_addr, // serial register address
    input wire logic [7:0] i_reg_wdata, // write byte
    output logic [7:0] o_reg_rdata, // read byte
    output logic o_reg_rvalid, // read answer pulse
    input wire logic i_wake_pin, // wake pin level
    input wire logic [7:0] i_master_tick, // master tick code
    input wire logic [7:0] i_sample_period_factor, // sample factor code, 0 means 1
    input wire tmlp_pkg::tmlp_touch_t i_live_touch, // live touch state
    input wire logic i_event_valid, // touch event strobe
    input wire tmlp_pkg::tmlp_touch_t i_event, // touch event word
    output logic o_event_ready, // FIFO has room
    input wire logic i_irq_request, // interrupt source pulse
    output logic o_irq_fire, // spaced interrupt pulse
    output logic o_scan_strobe, // start one electrode scan
    output tmlp_pkg::tmlp_mode_t o_mode, // decoded mode
    output tmlp_pkg::tmlp_lp_state_t o_lp_state, // scan period state
    output logic o_soft_reset // controller reset pulse
);
    localparam int TICK_CYCLES = `TMLP_FIXED_TICK_MS * MS_CYCLES;
    generate
        if (MS_CYCLES < 1 || FIFO_DEPTH < `TMLP_FIFO_LIMIT) begin : g_bad
            $error("tmlp_top: bad MS_CYCLES or FIFO_DEPTH");
        end
    endgenerate

    logic rst_meta;
    logic rst_n;
    logic [7:0] mode_control;
    logic [7:0] low_power_timing;
    tmlp_pkg::tmlp_mode_t mode;
    logic soft_rst;
    logic wake_q;
    logic wake_fall;
    logic serial_on;
    logic wr_ok;
    logic [31:0] tick_cnt;
    logic [31:0] tick_limit;
    logic tick;
    logic [7:0] tick_sum;
    logic [3:0] cycle_mult;
    logic [5:0] sample_factor;
    logic [2:0] idle_timeout_factor;
    logic [4:0] sleep_cycle_factor;
    logic lp_allowed;
    logic [15:0] scan_cnt;
    logic [15:0] scan_target;
    logic [15:0] normal_period;
    logic [15:0] slow_period;
    logic [15:0] idle_cnt;
    logic [15:0] idle_interface_timeout;
    tmlp_pkg::tmlp_lp_state_t lp_state;
    tmlp_pkg::tmlp_lp_state_t next_lp_state;
    logic touch_seen;
    logic [3:0] interrupt_spacing_factor;
    logic [7:0] spacing_target;
    logic [7:0] spacing_cnt;
    logic irq_pending;
    logic irq_fire;
    logic overflow;
    logic fifo_clear;
    logic fifo_pop;
    logic fifo_valid;
    logic [4:0] fifo_head;
    logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
    logic fifo_ready;
    logic [7:0] read_byte;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        case ({mode_control[`TMLP_MODE_SCAN], mode_control[`TMLP_MODE_DCOFF]})
            2'b11: mode = tmlp_pkg::MODE_CONT_RUN;
            2'b10: mode = tmlp_pkg::MODE_CYCLED_RUN;
            2'b01: mode = tmlp_pkg::MODE_IDLE_STOP;
            default: mode = tmlp_pkg::MODE_OFF_STOP;
        endcase
    end

    // both duty-cycled modes shut the serial side; only the wake pin reopens it
    assign serial_on = (mode == tmlp_pkg::MODE_CONT_RUN)
        || (mode == tmlp_pkg::MODE_IDLE_STOP);
    assign wr_ok = i_reg_wr && serial_on;
    assign wake_fall = wake_q && !i_wake_pin;
    assign soft_rst = wr_ok && (i_reg_addr == `TMLP_ADDR_MODE)
        && !i_reg_wdata[`TMLP_MODE_SOFTRST];

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b1;
        end else begin
            wake_q <= i_wake_pin;
        end
    end

    // mode control: a wake edge beats a same-cycle write of the duty bit
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_control <= `TMLP_MODE_RESET;
        end else if (soft_rst) begin
            mode_control <= `TMLP_MODE_RESET;
        end else begin
            if (wr_ok && i_reg_addr == `TMLP_ADDR_MODE) begin
                mode_control <= i_reg_wdata & 8'hf7;
            end
            if (wake_fall) begin
                mode_control[`TMLP_MODE_DCOFF] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_timing <= `TMLP_LOWPWR_RESET;
        end else if (soft_rst) begin
            low_power_timing <= `TMLP_LOWPWR_RESET;
        end else if (wr_ok && i_reg_addr == `TMLP_ADDR_LOWPWR
            && mode == tmlp_pkg::MODE_IDLE_STOP) begin
            low_power_timing <= i_reg_wdata;
        end
    end

    // primary tick: programmed period only in continuous run
    assign tick_sum = i_master_tick + 8'(`TMLP_TICK_OFFSET_MS);
    assign tick_limit = (mode == tmlp_pkg::MODE_CONT_RUN)
        ? 32'(tick_sum) * 32'(MS_CYCLES) : 32'(TICK_CYCLES);
    assign tick = (tick_cnt + 32'h1 >= tick_limit);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
        end else if (soft_rst || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    assign cycle_mult = 4'(tick_sum / 8'(`TMLP_TICK_DIV)) + 4'h1;
    assign sample_factor = 6'(i_sample_period_factor[4:0]) + 6'h1;
    assign idle_timeout_factor = low_power_timing[`TMLP_LP_IDLE];
    assign sleep_cycle_factor = low_power_timing[`TMLP_LP_SLEEP];
    assign lp_allowed = (idle_timeout_factor != 3'h0)
        && (sleep_cycle_factor != 5'h0);
    // periods in 8ms primary ticks
    assign normal_period = 16'(cycle_mult) * 16'(sample_factor)
        * 16'(`TMLP_DEBOUNCE);
    assign slow_period = normal_period * 16'(sleep_cycle_factor);
    assign idle_interface_timeout = 16'(cycle_mult) * 16'(sample_factor)
        * 16'(idle_timeout_factor) * 16'(`TMLP_IDLE_MULT);
    assign touch_seen = i_live_touch.touched || (i_event_valid && i_event.touched);

    always_comb begin
        case (mode)
            tmlp_pkg::MODE_CONT_RUN: scan_target = 16'(sample_factor);
            tmlp_pkg::MODE_CYCLED_RUN:
                scan_target = (lp_state == tmlp_pkg::LP_SLOW) ? slow_period : normal_period;
            default: scan_target = 16'hffff;
        endcase
    end

    always_comb begin
        next_lp_state = lp_state;
        case (lp_state)
            tmlp_pkg::LP_NORMAL: begin
                if (lp_allowed && tick && idle_cnt + 16'h1 >= idle_interface_timeout
                    && !touch_seen) begin
                    next_lp_state = tmlp_pkg::LP_SLOW;
                end
            end
            tmlp_pkg::LP_SLOW: begin
                if (touch_seen || !lp_allowed) begin
                    next_lp_state = tmlp_pkg::LP_NORMAL;
                end
            end
            default: next_lp_state = tmlp_pkg::LP_NORMAL;
        endcase
    end

    // leaving cycled run drops the adaptation back to its start point
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_state <= tmlp_pkg::LP_NORMAL;
        end else if (soft_rst || mode != tmlp_pkg::MODE_CYCLED_RUN) begin
            lp_state <= tmlp_pkg::LP_NORMAL;
        end else begin
            lp_state <= next_lp_state;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= '0;
        end else if (soft_rst || touch_seen || lp_state != tmlp_pkg::LP_NORMAL
            || mode != tmlp_pkg::MODE_CYCLED_RUN) begin
            idle_cnt <= '0;
        end else if (tick) begin
            idle_cnt <= idle_cnt + 16'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt <= '0;
            o_scan_strobe <= 1'b0;
        end else if (soft_rst || !mode_control[`TMLP_MODE_SCAN]
            || next_lp_state != lp_state) begin
            scan_cnt <= '0;
            o_scan_strobe <= 1'b0;
        end else if (tick) begin
            scan_cnt <= (scan_cnt + 16'h1 >= scan_target) ? '0 : scan_cnt + 16'h1;
            o_scan_strobe <= (scan_cnt + 16'h1 >= scan_target);
        end else begin
            o_scan_strobe <= 1'b0;
        end
    end

    // interrupt spacing: hold a request until the gap since the last has run out
    assign interrupt_spacing_factor = 4'(mode_control[`TMLP_MODE_SPACING]) + 4'h1;
    assign spacing_target = (mode == tmlp_pkg::MODE_CYCLED_RUN)
        ? 8'(cycle_mult) * 8'(interrupt_spacing_factor) * 8'(`TMLP_SPACING_MULT)
        : 8'(interrupt_spacing_factor) * 8'(`TMLP_SPACING_MULT);
    assign irq_fire = irq_pending && (spacing_cnt >= spacing_target);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending <= 1'b0;
            spacing_cnt <= 8'hff;
            o_irq_fire <= 1'b0;
        end else if (soft_rst || !mode_control[`TMLP_MODE_INTERRUPT_OUT_ENABLE]) begin
            irq_pending <= 1'b0;
            spacing_cnt <= 8'hff;
            o_irq_fire <= 1'b0;
        end else begin
            irq_pending <= (irq_pending && !irq_fire) || i_irq_request;
            o_irq_fire <= irq_fire;
            if (irq_fire) begin
                spacing_cnt <= '0;
            end else if (tick && spacing_cnt != 8'hff) begin
                spacing_cnt <= spacing_cnt + 8'h1;
            end
        end
    end

    // writes clear the FIFO even in continuous run: it is a flush, not a setting
    assign fifo_clear = soft_rst || (wr_ok && i_reg_addr == `TMLP_ADDR_FIFO);
    assign fifo_pop = i_reg_rd && serial_on && i_reg_addr == `TMLP_ADDR_FIFO;

    tmlp_fifo #(
        .WIDTH(5),
        .DEPTH(FIFO_DEPTH),
        .LIMIT(`TMLP_FIFO_LIMIT)
    ) u_fifo (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_clear(fifo_clear),
        .i_s_valid(i_event_valid),
        .o_s_ready(fifo_ready),
        .i_s_data(i_event),
        .o_m_valid(fifo_valid),
        .i_m_ready(fifo_pop),
        .o_m_data(fifo_head),
        .o_count(fifo_count)
    );

    // overflow set wins over a same-cycle flush
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow <= 1'b0;
        end else if (i_event_valid && !fifo_ready) begin
            overflow <= 1'b1;
        end else if (fifo_clear) begin
            overflow <= 1'b0;
        end
    end

    always_comb begin
        case (i_reg_addr)
            `TMLP_ADDR_FIFO: read_byte = {(fifo_count > 'd1), !fifo_valid, overflow,
                fifo_valid ? fifo_head : 5'h00};
            `TMLP_ADDR_LIVE: read_byte = i_live_touch.touched
                ? {3'h0, 1'b1, i_live_touch.position} : 8'h00;
            `TMLP_ADDR_LOWPWR: read_byte = low_power_timing;
            `TMLP_ADDR_MODE: read_byte = mode_control;
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd && serial_on;
            if (i_reg_rd && serial_on) begin
                o_reg_rdata <= read_byte;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_mode <= tmlp_pkg::MODE_IDLE_STOP;
            o_lp_state <= tmlp_pkg::LP_NORMAL;
            o_soft_reset <= 1'b0;
            o_event_ready <= 1'b0;
        end else begin
            o_mode <= mode;
            o_lp_state <= lp_state;
            o_soft_reset <= soft_rst;
            o_event_ready <= fifo_ready;
        end
    end
endmodule : tmlp_top
`default_nettype wire

// file: tb/tmlp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmlp_host_model #(
    parameter int LOW_CYCLES = 3
) (
    input wire logic i_clk, // core clock
    input wire logic i_wake_req, // bench asks for one wake pulse
    output logic o_wake_pin // wake pin, idle high
);
    int unsigned low_left = 0;

    // pin only moves just after an edge, like a real host gpio
    always_ff @(posedge i_clk) begin
        if (i_wake_req) begin
            low_left <= LOW_CYCLES;
        end else if (low_left != 0) begin
            low_left <= low_left - 1;
        end
    end
    assign o_wake_pin = (low_left == 0);
endmodule : tmlp_host_model
`default_nettype wire

// file: tb/tmlp_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tmlp_top_monitor (
    input wire logic i_core_clk, // core clock
    input wire logic i_arst_n, // reset, active low
    input wire logic i_reg_wr, // write strobe
    input wire logic i_reg_rd, // read strobe
    input wire logic [7:0] i_reg_addr, // address
    input wire logic [7:0] i_reg_wdata, // write byte
    input wire logic [7:0] o_reg_rdata, // read byte
    input wire logic o_reg_rvalid, // read answer
    input wire logic i_wake_pin, // wake pin
    input wire tmlp_pkg::tmlp_touch_t i_live_touch, // live touch
    input wire logic o_scan_strobe, // scan start
    input wire tmlp_pkg::tmlp_mode_t o_mode, // decoded mode
    input wire tmlp_pkg::tmlp_lp_state_t o_lp_state, // period state
    input wire logic o_soft_reset // soft reset pulse
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    // mode held three cycles so the one-cycle lag of o_mode cannot mislead
    AST_ANSWER: assert property ((o_mode == tmlp_pkg::MODE_IDLE_STOP)[*3] ##0 i_reg_rd
        |=> o_reg_rvalid) else $error("read in idle stop not answered");
    AST_OFF_SILENT: assert property ((o_mode == tmlp_pkg::MODE_OFF_STOP)[*3] ##0 i_reg_rd
        |=> !o_reg_rvalid) else $error("read answered in off stop");
    AST_ANSWER_CAUSE: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read answer without read");
    AST_LIVE: assert property ((o_mode == tmlp_pkg::MODE_IDLE_STOP)[*3] ##0
        (i_reg_rd && i_reg_addr == 8'h02) |=> o_reg_rdata == ($past(i_live_touch.touched)
        ? {4'h1, $past(i_live_touch.position)} : 8'h00)) else $error("live status wrong");
    AST_LP_CYCLED: assert property ((o_mode != tmlp_pkg::MODE_CYCLED_RUN)[*2]
        |-> o_lp_state == tmlp_pkg::LP_NORMAL) else $error("slow period outside cycled run");
    AST_TOUCH_WAKES: assert property ((o_lp_state == tmlp_pkg::LP_SLOW && i_live_touch.touched)
        |-> ##[1:2] o_lp_state == tmlp_pkg::LP_NORMAL) else $error("touch kept slow period");
    AST_SOFT_RESET: assert property ((o_mode == tmlp_pkg::MODE_IDLE_STOP)[*3] ##0
        (i_reg_wr && i_reg_addr == 8'h0a && !i_reg_wdata[4]) |=> o_soft_reset)
        else $error("soft reset missing");
    AST_RESET_CAUSE: assert property (o_soft_reset |-> $past(i_reg_wr)
        && $past(i_reg_addr) == 8'h0a && !$past(i_reg_wdata[4])) else $error("stray soft reset");
    AST_WAKE: assert property (($fell(i_wake_pin) && !i_reg_wr && o_mode == tmlp_pkg::MODE_OFF_STOP)
        |-> ##[1:3] o_mode == tmlp_pkg::MODE_IDLE_STOP) else $error("wake did not leave off stop");
    AST_STOP_NO_SCAN: assert property ((o_mode inside {tmlp_pkg::MODE_IDLE_STOP,
        tmlp_pkg::MODE_OFF_STOP})[*3] |-> !o_scan_strobe) else $error("scan in stop mode");
endmodule : tmlp_top_monitor

bind tmlp_top tmlp_top_monitor u_monitor (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_wake_pin(i_wake_pin), .i_live_touch(i_live_touch), .o_scan_strobe(o_scan_strobe),
    .o_mode(o_mode), .o_lp_state(o_lp_state), .o_soft_reset(o_soft_reset));
`default_nettype wire

// file: tb/test_touch_mode_lowpower_output.sv
`timescale 1ns/10ps
`default_nettype none
module test_touch_mode_lowpower_output;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic ev_valid = 1'b0;
    logic wake_req = 1'b0;
    logic irq_req = 1'b0;
    tmlp_pkg::tmlp_touch_t live = '0;
    tmlp_pkg::tmlp_touch_t ev = '0;
    logic [7:0] rdata;
    logic rvalid, wake_pin, ev_ready, irq_fire, scan, soft_rst;
    tmlp_pkg::tmlp_mode_t mode;
    tmlp_pkg::tmlp_lp_state_t lp;
    logic [7:0] got_d;
    logic got_v;
    int n_fail = 0;
    int comparisons = 0;
    int i, c, g1, g2;

    initial begin
        forever #2 clk = ~clk;
    end

    // MS_CYCLES of 1 makes the fixed tick 8 cycles
    tmlp_top #(.MS_CYCLES(1), .FIFO_DEPTH(32)) DUT (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_wake_pin(wake_pin),
        .i_master_tick(8'h00), .i_sample_period_factor(8'h00), .i_live_touch(live),
        .i_event_valid(ev_valid), .i_event(ev), .o_event_ready(ev_ready), .i_irq_request(irq_req),
        .o_irq_fire(irq_fire), .o_scan_strobe(scan), .o_mode(mode), .o_lp_state(lp),
        .o_soft_reset(soft_rst));

    tmlp_host_model #(.LOW_CYCLES(3)) u_host (.i_clk(clk), .i_wake_req(wake_req),
        .o_wake_pin(wake_pin));

    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    // answer is registered: look one step after the taking edge
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        got_v = rvalid;
        got_d = rdata;
        @(posedge clk);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk({7'h00, got_v}, 8'h01);
        chk(got_d, exp);
    endtask : rdc

    task automatic waitmode(input tmlp_pkg::tmlp_mode_t m);
        for (int k = 0; k < 20 && mode !== m; k++) @(posedge clk);
        chk(8'(mode), 8'(m));
        if (mode !== m) test_done();
    endtask : waitmode

    // ref arguments cannot take non-blocking writes, so pick the pin here
    task automatic pulse(input logic wake);
        if (wake) begin
            wake_req <= 1'b1;
        end else begin
            irq_req <= 1'b1;
        end
        @(posedge clk);
        wake_req <= 1'b0;
        irq_req <= 1'b0;
    endtask : pulse

    task automatic ev_push(input logic t, input logic [3:0] p);
        ev_valid <= 1'b1;
        ev <= {t, p};
        @(posedge clk);
        ev_valid <= 1'b0;
        @(posedge clk);
    endtask : ev_push

    task automatic next_scan(output int g);
        g = 1;
        @(posedge clk);
        while (scan !== 1'b1 && g < 600) begin
            @(posedge clk);
            g++;
        end
        if (g >= 600) begin
            n_fail++;
            test_done();
        end
    endtask : next_scan

    task automatic fires(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            if (irq_fire === 1'b1) cnt++;
        end
    endtask : fires

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(8'(mode), 8'(tmlp_pkg::MODE_IDLE_STOP));
        rdc(8'h0a, 8'h14);
        rdc(8'h08, 8'h00);
        rdc(8'h00, 8'h40);
        rdc(8'h05, 8'h00);
        live <= 5'h17;
        rdc(8'h02, 8'h17);
        wr(8'h02, 8'hff);
        live <= 5'h03;
        rdc(8'h02, 8'h00);
        for (i = 0; i < 31; i++) ev_push(i[0], {1'b0, i[2:0]});
        chk({7'h00, ev_ready}, 8'h00);
        // entry 30 was dropped, so overflow shows on every read
        for (i = 0; i < 30; i++) rdc(8'h00, {i < 29, 2'b01, i[0], 1'b0, i[2:0]});
        rdc(8'h00, 8'h60);
        wr(8'h00, 8'h00);
        rdc(8'h00, 8'h40);
        wr(8'h08, 8'he2);
        rdc(8'h08, 8'he2);
        wr(8'h0a, 8'h15);
        waitmode(tmlp_pkg::MODE_CONT_RUN);
        wr(8'h08, 8'h00);
        rdc(8'h08, 8'he2);
        wr(8'h0a, 8'h10);
        waitmode(tmlp_pkg::MODE_OFF_STOP);
        // o_mode lags a cycle; wait so the off-stop silence check is armed
        @(posedge clk);
        rd(8'h0a);
        chk({7'h00, got_v}, 8'h00);
        pulse(1'b1);
        waitmode(tmlp_pkg::MODE_IDLE_STOP);
        rdc(8'h0a, 8'h14);
        wr(8'h0a, 8'h11);
        waitmode(tmlp_pkg::MODE_CYCLED_RUN);
        chk(8'(lp), 8'(tmlp_pkg::LP_NORMAL));
        next_scan(g1);
        next_scan(g2);
        chk(8'(g2), 8'd32);
        for (i = 0; i < 500 && lp !== tmlp_pkg::LP_SLOW; i++) @(posedge clk);
        if (i >= 500) begin
            n_fail++;
            test_done();
        end
        // idle factor 7: 7*6 ticks of 8 cycles
        chk({7'h00, (g1 + g2 + i) inside {[320:352]}}, 8'h01);
        next_scan(g1);
        next_scan(g2);
        chk(8'(g2), 8'd64);
        live <= 5'h12;
        repeat (3) @(posedge clk);
        chk(8'(lp), 8'(tmlp_pkg::LP_NORMAL));
        live <= 5'h00;
        rd(8'h0a);
        chk({7'h00, got_v}, 8'h00);
        pulse(1'b1);
        waitmode(tmlp_pkg::MODE_CONT_RUN);
        // continuous run: tick is (code 0 + 5) ms of one cycle each, scan every tick
        next_scan(g1);
        next_scan(g2);
        chk(8'(g2), 8'd5);
        rdc(8'h0a, 8'h15);
        wr(8'h0a, 8'h77);
        pulse(1'b0);
        fires(10, c);
        chk(8'(c), 8'd1);
        pulse(irq_req);
        fires(20, c);
        chk(8'(c), 8'd0);
        fires(100, c);
        chk(8'(c), 8'd1);
        wr(8'h0a, 8'h75);
        fires(100, c);
        pulse(1'b0);
        fires(100, c);
        chk(8'(c), 8'd0);
        wr(8'h0a, 8'h14);
        waitmode(tmlp_pkg::MODE_IDLE_STOP);
        wr(8'h08, 8'h22);
        wr(8'h0a, 8'h05);
        rdc(8'h0a, 8'h14);
        rdc(8'h08, 8'h00);
        test_done();
    end
endmodule : test_touch_mode_lowpower_output
`default_nettype wire
